// File: src/bdp_download_port.sv
// byte download port with readback shifter
`timescale 1ns/1ps
`include "bdp_defines.svh"
module bdp_download_port #(
	parameter bit MSB_FIRST = 1'b0
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire bdp_pkg::bdp_byte_t host_data_lines,
	input wire logic select_strobe,
	input wire logic byte_strobe,
	input wire logic [2:0] board_address_jumper,
	input wire logic [3:0] bus_enable_jumper,
	input wire logic shifter_route_jumper,
	input wire bdp_pkg::bdp_word_t output_bus_one,
	input wire bdp_pkg::bdp_word_t output_bus_two,
	output bdp_pkg::bdp_word_t input_bus_one,
	output logic input_bus_one_oe,
	output bdp_pkg::bdp_word_t input_bus_two,
	output logic input_bus_two_oe,
	output bdp_pkg::bdp_word_t input_bus_three,
	output logic input_bus_three_oe,
	output bdp_pkg::bdp_word_t control_word_bus,
	output logic control_word_bus_oe,
	output logic serial_readback
);
	import bdp_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic sel_strobe_d;
		logic byte_strobe_d;
		logic commit_d;
		logic load_d;
		logic clock_d;
		bdp_byte_t target_select_reg;
		bdp_byte_t byte_staging_reg;
		logic [7:0][7:0] data_bytes;
		bdp_shift_t output_capture_shifter;
		logic [3:0] oe;
		logic serial;
	} bdp_state_s;

	bdp_state_s st_reg;
	bdp_state_s st_next;

	// staged bytes pass through the buffer on their way to the commit
	logic buf_in_valid;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_out_ready;
	bdp_byte_t buf_out_data;
	bdp_byte_t commit_select;
	logic commit_fall;
	logic commit_hit;

	// word made of two data bytes, high index in upper half
	function automatic bdp_word_t bdp_pair(input logic [7:0][7:0] b, input bdp_index_t lo);
		bdp_pair = {b[lo + 3'h1], b[lo]};
	endfunction

	// ------------------------------------------------------------
	// commit detection
	// ------------------------------------------------------------
	// the commit is judged on the value the strobe is loading, so it lands
	// in the same cycle as the select strobe edge
	assign commit_select = host_data_lines;
	assign commit_fall = select_strobe & ~st_reg.sel_strobe_d & st_reg.commit_d
		& ~commit_select[`BDP_COMMIT_BIT];
	assign commit_hit = commit_fall
		& (commit_select[`BDP_BOARD_HI:`BDP_BOARD_LO] == board_address_jumper);
	// two stalled staging words block the next byte strobe; nothing here stalls
	assign buf_in_valid = byte_strobe & ~st_reg.byte_strobe_d;
	assign buf_out_ready = 1'b1;

	bdp_skid_buf u_stage_buf (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(host_data_lines),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_data(buf_out_data)
	);

	// next state
	always_comb begin
		st_next = st_reg;
		st_next.sel_strobe_d = select_strobe;
		st_next.byte_strobe_d = byte_strobe;
		st_next.load_d = st_reg.data_bytes[`BDP_IDX_CTL_LO][`BDP_SHIFT_LOAD_BIT];
		st_next.clock_d = st_reg.data_bytes[`BDP_IDX_CTL_LO][`BDP_SHIFT_CLOCK_BIT];
		if (select_strobe && !st_reg.sel_strobe_d) begin
			st_next.target_select_reg = host_data_lines;
			st_next.commit_d = host_data_lines[`BDP_COMMIT_BIT];
		end
		if (buf_out_valid) begin
			st_next.byte_staging_reg = buf_out_data;
		end
		if (commit_hit) begin
			// index field picks one of eight bytes
			st_next.data_bytes[commit_select[`BDP_INDEX_HI:`BDP_INDEX_LO]] = st_reg.byte_staging_reg;
		end
		// shifter driven only from control word bits
		if (st_next.load_d && !st_reg.load_d) begin
			st_next.output_capture_shifter = {output_bus_one, output_bus_two};
		end else if (st_next.clock_d && !st_reg.clock_d) begin
			if (MSB_FIRST) begin
				st_next.output_capture_shifter = {st_reg.output_capture_shifter[30:0], 1'b0};
			end else begin
				st_next.output_capture_shifter = {1'b0, st_reg.output_capture_shifter[31:1]};
			end
		end
		st_next.serial = shifter_route_jumper & (MSB_FIRST ? st_next.output_capture_shifter[31]
			: st_next.output_capture_shifter[0]);
		st_next.oe = bus_enable_jumper;
	end

	// registered state; commit detector starts low
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// outputs straight from flip-flops
	// ------------------------------------------------------------
	assign input_bus_three = bdp_pair(st_reg.data_bytes, `BDP_IDX_IN3_LO);
	assign input_bus_two = bdp_pair(st_reg.data_bytes, `BDP_IDX_IN2_LO);
	assign control_word_bus = bdp_pair(st_reg.data_bytes, `BDP_IDX_CTL_LO);
	assign input_bus_one = bdp_pair(st_reg.data_bytes, `BDP_IDX_IN1_LO);
	assign input_bus_one_oe = st_reg.oe[0];
	assign input_bus_two_oe = st_reg.oe[1];
	assign input_bus_three_oe = st_reg.oe[2];
	assign control_word_bus_oe = st_reg.oe[3];
	assign serial_readback = st_reg.serial;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_sel_rise;
		select_strobe && !st_reg.sel_strobe_d;
	endsequence

	a_select_capture: assert property (@(posedge sys_clk) disable iff (rst)
		s_sel_rise |=> st_reg.target_select_reg == $past(host_data_lines))
		else $error("target select not loaded on select strobe");

	a_commit_writes: assert property (@(posedge sys_clk) disable iff (rst)
		commit_hit |=> st_reg.data_bytes[$past(commit_select[2:0])] == $past(st_reg.byte_staging_reg))
		else $error("commit did not copy staged byte");

	a_foreign_board: assert property (@(posedge sys_clk) disable iff (rst)
		(s_sel_rise and (host_data_lines[5:3] != board_address_jumper)) |=> $stable(st_reg.data_bytes))
		else $error("data bytes changed for another board");

	a_no_commit_hold: assert property (@(posedge sys_clk) disable iff (rst)
		!commit_hit |=> $stable(st_reg.data_bytes))
		else $error("data bytes changed without commit");

	a_shift_load: assert property (@(posedge sys_clk) disable iff (rst)
		(st_reg.data_bytes[4][3] && !st_reg.load_d)
		|=> st_reg.output_capture_shifter == {$past(output_bus_one), $past(output_bus_two)})
		else $error("shifter not loaded on load bit rise");

	a_shift_step: assert property (@(posedge sys_clk) disable iff (rst)
		(st_reg.data_bytes[4][2] && !st_reg.clock_d && !(st_reg.data_bytes[4][3] && !st_reg.load_d) && !MSB_FIRST)
		|=> st_reg.output_capture_shifter == {1'b0, $past(st_reg.output_capture_shifter[31:1])})
		else $error("shifter did not advance one bit");

	a_shift_quiet: assert property (@(posedge sys_clk) disable iff (rst)
		($stable(st_reg.data_bytes[4][3:2]) && $past($stable(st_reg.data_bytes[4][3:2])))
		|=> $stable(st_reg.output_capture_shifter))
		else $error("shifter moved without control bit edge");

	a_readback_gate: assert property (@(posedge sys_clk) disable iff (rst)
		!shifter_route_jumper |=> !serial_readback)
		else $error("readback driven without route jumper");

	a_bus_release: assert property (@(posedge sys_clk) disable iff (rst)
		!bus_enable_jumper[3] |=> !control_word_bus_oe)
		else $error("control bus driven while disabled");

	// msb-first build walks the word toward bit 31 and fills from below
	a_shift_msb: assert property (@(posedge sys_clk) disable iff (rst)
		(st_reg.data_bytes[4][2] && !st_reg.clock_d && !(st_reg.data_bytes[4][3] && !st_reg.load_d) && MSB_FIRST)
		|=> st_reg.output_capture_shifter == {$past(st_reg.output_capture_shifter[30:0]), 1'b0})
		else $error("shifter did not advance one bit toward msb");

	// readback carries the bit that leaves the shifter first
	a_readback_bit: assert property (@(posedge sys_clk) disable iff (rst)
		shifter_route_jumper |=> serial_readback == (MSB_FIRST ? st_reg.output_capture_shifter[31]
		: st_reg.output_capture_shifter[0]))
		else $error("readback does not show the shifter end bit");

	// every enable output is last cycle's jumper setting, one cycle late by design
	a_oe_follow: assert property (@(posedge sys_clk) disable iff (rst)
		1'b1 |=> {control_word_bus_oe, input_bus_three_oe, input_bus_two_oe, input_bus_one_oe}
		== $past(bus_enable_jumper))
		else $error("bus enables do not follow their jumpers");

	// ------------------------------------------------------------
	// staging path
	// ------------------------------------------------------------
	// the buffer drains every cycle, so a byte strobe is never refused
	a_stage_accept: assert property (@(posedge sys_clk) disable iff (rst)
		buf_in_valid |-> buf_in_ready)
		else $error("staging buffer refused a byte strobe");

	a_staging_load: assert property (@(posedge sys_clk) disable iff (rst)
		buf_out_valid |=> st_reg.byte_staging_reg == $past(buf_out_data))
		else $error("staging register missed the buffered byte");
endmodule

// File: src/bdp_defines.svh
// constants for the byte download port: field positions, reset values, decode
`ifndef BDP_DEFINES_SVH
`define BDP_DEFINES_SVH

// ------------------------------------------------------------
// target select field layout
// ------------------------------------------------------------
`define BDP_COMMIT_BIT 6
`define BDP_BOARD_HI 5
`define BDP_BOARD_LO 3
`define BDP_INDEX_HI 2
`define BDP_INDEX_LO 0

// ------------------------------------------------------------
// register index decode
// ------------------------------------------------------------
`define BDP_IDX_IN3_LO 3'h0
`define BDP_IDX_IN3_HI 3'h1
`define BDP_IDX_IN2_LO 3'h2
`define BDP_IDX_IN2_HI 3'h3
`define BDP_IDX_CTL_LO 3'h4
`define BDP_IDX_CTL_HI 3'h5
`define BDP_IDX_IN1_LO 3'h6
`define BDP_IDX_IN1_HI 3'h7

// ------------------------------------------------------------
// control word bits and reset values
// ------------------------------------------------------------
`define BDP_SHIFT_CLOCK_BIT 2
`define BDP_SHIFT_LOAD_BIT 3
`define BDP_BYTE_RST 8'h00
`define BDP_WORD_RST 16'h0000
`define BDP_SHIFT_RST 32'h0000_0000

`endif

// File: src/bdp_pkg.sv
// types shared by the byte download port
package bdp_pkg;
	typedef logic [7:0] bdp_byte_t;
	typedef logic [15:0] bdp_word_t;
	typedef logic [31:0] bdp_shift_t;
	typedef logic [2:0] bdp_index_t;
endpackage

// File: src/bdp_skid_buf.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module bdp_skid_buf (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire bdp_pkg::bdp_byte_t in_data,
	output logic out_valid,
	input wire logic out_ready,
	output bdp_pkg::bdp_byte_t out_data
);
	import bdp_pkg::*;

	typedef struct packed {
		logic [1:0] vld;
		bdp_byte_t d0;
		bdp_byte_t d1;
	} bdp_buf_s;

	bdp_buf_s st_reg;
	bdp_buf_s st_next;
	logic push;
	logic pop;

	// ------------------------------------------------------------
	// entry 0 is the head; entry 1 catches a word while head stalls
	// ------------------------------------------------------------
	assign in_ready = ~st_reg.vld[1];
	assign out_valid = st_reg.vld[0];
	assign out_data = st_reg.d0;
	assign push = in_valid & in_ready;
	assign pop = st_reg.vld[0] & out_ready;

	// next state: pop shifts entry 1 down, push fills lowest free slot
	always_comb begin
		st_next = st_reg;
		if (pop) begin
			st_next.d0 = st_reg.d1;
			st_next.vld = {1'b0, st_reg.vld[1]};
		end
		if (push) begin
			if (!st_next.vld[0]) begin
				st_next.d0 = in_data;
				st_next.vld[0] = 1'b1;
			end else begin
				st_next.d1 = in_data;
				st_next.vld[1] = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// no word ever sits behind an empty head
	a_buf_order: assert property (@(posedge sys_clk) disable iff (rst)
		st_reg.vld[1] |-> st_reg.vld[0])
		else $error("buffer holds a tail word without a head");
endmodule

// File: test/bdp_host_model.sv
// host parallel port model that strobes bytes into the download port
`timescale 1ns/1ps
module bdp_host_model (
	input wire logic sys_clk,
	output bdp_pkg::bdp_byte_t host_data_lines,
	output logic select_strobe,
	output logic byte_strobe
);
	import bdp_pkg::*;
	initial begin
		host_data_lines = 8'h00;
		select_strobe = 1'b0;
		byte_strobe = 1'b0;
	end
	// one strobe, two cycles high and two low; data inverted after so stale data never passes
	task automatic pulse(input logic sel, input bdp_byte_t d);
		@(posedge sys_clk);
		host_data_lines <= d;
		select_strobe <= sel;
		byte_strobe <= !sel;
		repeat (2) @(posedge sys_clk);
		select_strobe <= 1'b0;
		byte_strobe <= 1'b0;
		host_data_lines <= ~d;
		repeat (2) @(posedge sys_clk);
	endtask
	// one byte per load, so a word takes two of these
	task automatic load(input logic [2:0] board, input bdp_index_t idx, input bdp_byte_t d);
		pulse(1'b0, d);
		pulse(1'b1, {2'b01, board, idx});
		pulse(1'b1, {2'b00, board, idx});
	endtask
endmodule

// File: test/tb.sv
// self-checking bench for the byte download port
`timescale 1ns/1ps
module tb;
	import bdp_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] board_address_jumper = 3'h0;
	logic [3:0] bus_enable_jumper = 4'hf;
	logic shifter_route_jumper = 1'b1;
	bdp_word_t output_bus_one = 16'h0000;
	bdp_word_t output_bus_two = 16'h0000;
	bdp_byte_t host_data_lines;
	logic select_strobe, byte_strobe, serial_readback, serial_msb;
	bdp_word_t in1, in2, in3, ctl;
	logic in1_oe, in2_oe, in3_oe, ctl_oe;
	logic [63:0] bus_queue[$];
	logic [63:0] prev_bus = 64'h0;
	bdp_byte_t exp_reg[8] = '{default: 8'h00};
	bdp_shift_t exp_sr;
	bdp_shift_t exp_sl;
	logic [3:0] en_tab[4] = '{4'h0, 4'h5, 4'ha, 4'hf};
	int n_fail = 0;
	int compares = 0;
	int cycles = 0;
	always #5 sys_clk = ~sys_clk;
	bdp_host_model host (.sys_clk(sys_clk), .host_data_lines(host_data_lines), .select_strobe(select_strobe),
		.byte_strobe(byte_strobe));
	bdp_download_port #(.MSB_FIRST(1'b0)) uut (.sys_clk(sys_clk), .rst(rst), .host_data_lines(host_data_lines),
		.select_strobe(select_strobe), .byte_strobe(byte_strobe), .board_address_jumper(board_address_jumper),
		.bus_enable_jumper(bus_enable_jumper), .shifter_route_jumper(shifter_route_jumper),
		.output_bus_one(output_bus_one), .output_bus_two(output_bus_two), .input_bus_one(in1),
		.input_bus_one_oe(in1_oe), .input_bus_two(in2), .input_bus_two_oe(in2_oe), .input_bus_three(in3),
		.input_bus_three_oe(in3_oe), .control_word_bus(ctl), .control_word_bus_oe(ctl_oe),
		.serial_readback(serial_readback));
	// msb-first build on the same pins; only its readback is watched
	bdp_download_port #(.MSB_FIRST(1'b1)) uut_msb (.sys_clk(sys_clk), .rst(rst),
		.host_data_lines(host_data_lines), .select_strobe(select_strobe), .byte_strobe(byte_strobe),
		.board_address_jumper(board_address_jumper), .bus_enable_jumper(bus_enable_jumper),
		.shifter_route_jumper(shifter_route_jumper), .output_bus_one(output_bus_one),
		.output_bus_two(output_bus_two), .input_bus_one(), .input_bus_one_oe(), .input_bus_two(),
		.input_bus_two_oe(), .input_bus_three(), .input_bus_three_oe(), .control_word_bus(),
		.control_word_bus_oe(), .serial_readback(serial_msb));
	// --------------------------------
	// compares and helpers
	// --------------------------------
	task automatic check_word(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: buses %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_bits(input logic [3:0] got, input logic [3:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: flags %b expected %b", $time, got, exp);
		end
	endtask
	function automatic logic [63:0] exp_bus();
		return {exp_reg[7], exp_reg[6], exp_reg[3], exp_reg[2], exp_reg[1], exp_reg[0], exp_reg[5], exp_reg[4]};
	endfunction
	// a miss on the board address must leave every register alone, so no note is queued
	task automatic set_reg(input bdp_index_t idx, input bdp_byte_t d, input logic hit);
		if (hit && exp_reg[idx] !== d) begin
			exp_reg[idx] = d;
			bus_queue.push_back(exp_bus());
		end
		host.load(hit ? board_address_jumper : ~board_address_jumper, idx, d);
	endtask
	// shifter answers a few edges after the control byte lands; both bit orders looked at
	task automatic check_serial(input logic e, input logic em);
		repeat (3) @(posedge sys_clk);
		check_bits({2'b00, serial_msb, serial_readback}, {2'b00, em, e});
	endtask
	task automatic end_sim();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// any bus change takes the oldest note; a change with no note is compared against no change
	always @(posedge sys_clk) begin
		if (!rst && {in1, in2, in3, ctl} !== prev_bus)
			check_word({in1, in2, in3, ctl}, bus_queue.size() ? bus_queue.pop_front() : prev_bus);
		prev_bus <= {in1, in2, in3, ctl};
		cycles++;
		if (cycles == 6000) begin
			n_fail++;
			$display("mismatch at %0t: timeout", $time);
			end_sim();
		end
	end
	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		void'($urandom(32'h04ff4098));
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		board_address_jumper <= 3'($urandom());
		// top bit set so the msb-first readback opens on a one
		output_bus_one <= 16'($urandom()) | 16'h8000;
		output_bus_two <= 16'($urandom()) | 16'h0001;
		@(posedge sys_clk);
		check_word({in1, in2, in3, ctl}, 64'h0);
		for (int i = 0; i < 8; i++)
			set_reg(3'(i), 8'($urandom()), 1'b1);
		set_reg(3'h2, ~exp_reg[2], 1'b0);
		host.pulse(1'b0, 8'h5a);
		host.pulse(1'b1, {2'b00, board_address_jumper, 3'h3});
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			bus_enable_jumper <= en_tab[i];
			repeat (3) @(posedge sys_clk);
			check_bits({ctl_oe, in3_oe, in2_oe, in1_oe}, en_tab[i]);
		end
		$display("test enables done");
		// the random control byte may already hold the load bit; clear it so the load sees a rise
		set_reg(3'h4, 8'h00, 1'b1);
		exp_sr = {output_bus_one, output_bus_two};
		exp_sl = exp_sr;
		set_reg(3'h4, 8'h08, 1'b1);
		check_serial(exp_sr[0], exp_sl[31]);
		output_bus_one <= ~output_bus_one;
		shifter_route_jumper <= 1'b0;
		check_serial(1'b0, 1'b0);
		shifter_route_jumper <= 1'b1;
		check_serial(exp_sr[0], exp_sl[31]);
		for (int k = 0; k < 32; k++) begin
			set_reg(3'h4, 8'h0c, 1'b1);
			exp_sr = exp_sr >> 1;
			exp_sl = exp_sl << 1;
			check_serial(exp_sr[0], exp_sl[31]);
			set_reg(3'h4, 8'h08, 1'b1);
		end
		$display("test shifter done");
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		check_word({in1, in2, in3, ctl}, 64'h0);
		rst <= 1'b0;
		exp_reg = '{default: 8'h00};
		bus_queue.delete();
		set_reg(3'h7, 8'ha5, 1'b1);
		repeat (5) @(posedge sys_clk);
		check_bits(4'(bus_queue.size()), 4'h0);
		$display("test reset done");
		end_sim();
	end
endmodule
